/* File: design/wdt_pkg.sv */
// Package for the free-running watchdog: register map, fields, reset values, timing.
// Assumes a 20 MHz system clock and a low-speed clock sampled as a synchronous input.
package wdt_pkg;
  // Register addresses, one byte each
  localparam logic [15:0] ADDR_CLEAR = 16'hF00E;
  localparam logic [15:0] ADDR_PERIOD = 16'hF00F;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hF010;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hF011;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hF012;
  // Clear-sequence keys
  localparam logic [7:0] KEY_FIRST = 8'h5A;
  localparam logic [7:0] KEY_SECOND = 8'hA5;
  // Reset values
  localparam logic [1:0] PERIOD_RESET = 2'h2;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h3;
  // Status bit positions
  localparam int STAT_NMI = 0;
  localparam int STAT_RESET = 1;
  // Low-speed clock edges per overflow period, at 32768 Hz; the 8s entry is one edge short to fit 18 bits
  localparam logic [17:0] OVF_TICKS_125MS = 18'h01000;
  localparam logic [17:0] OVF_TICKS_500MS = 18'h04000;
  localparam logic [17:0] OVF_TICKS_2S = 18'h10000;
  localparam logic [17:0] OVF_TICKS_8S = 18'h3FFFF;
  // Clear lockout after overflow, half a low-speed cycle
  localparam real CLK_SYS_NS = 50.0;
  localparam real LOCKOUT_NS = 15250.0;
  localparam int LOCKOUT_CYCLES = int'(LOCKOUT_NS / CLK_SYS_NS) < 1 ? 1 :
                                  int'(LOCKOUT_NS / CLK_SYS_NS - 0.5);
  // Width of the lockout counter
  localparam int LOCK_W = 9;
endpackage : wdt_pkg

/* File: design/wdt_tick_if.sv */
// Interface between the watchdog core and its tick/lockout helper.
// Assumes both ends share clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface wdt_tick_if;
  logic tick;
  logic lock_start;
  logic locked;
  modport core (input tick, input locked, output lock_start);
  modport helper (output tick, output locked, input lock_start);
endinterface : wdt_tick_if
`default_nettype wire

/* File: design/wdt_tick_gen.sv */
// Low-speed clock edge detector and post-overflow clear lockout timer.
// Assumes the low-speed clock is already synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module wdt_tick_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lsclk,
  input wire logic stop_mode,
  wdt_tick_if.helper tk
);
  import wdt_pkg::*;
  logic ls_prev_q;
  logic tick_q;
  logic [LOCK_W-1:0] lock_cnt_q;

  // Rising edge of low-speed clock; no ticks in stop mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ls_prev_q <= 1'b1; // No false edge if the pin is already high at release
      tick_q <= 1'b0;
    end else begin
      ls_prev_q <= lsclk;
      tick_q <= lsclk & ~ls_prev_q & ~stop_mode;
    end
  end

  // Lockout counts down after each overflow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_cnt_q <= '0;
    end else if (tk.lock_start) begin
      lock_cnt_q <= LOCK_W'(LOCKOUT_CYCLES);
    end else if (lock_cnt_q != '0) begin
      lock_cnt_q <= lock_cnt_q - 1'b1;
    end
  end

  assign tk.tick = tick_q;
  assign tk.locked = (lock_cnt_q != '0);
endmodule : wdt_tick_gen
`default_nettype wire

/* File: design/free_running_watchdog.sv */
// Free-running watchdog: counter, two-step clear sequence, NMI then reset.
// Assumes a byte register port with one-cycle strobes and read data next cycle.
// Overview of operation
// - Counter runs from reset, not stoppable by software
// - Two-bit field picks 125ms/500ms/2s/8s
// - First overflow raises non-maskable interrupt
// - Second uncleared overflow forces system reset
// - Clear needs 5A at pointer 0, A5 at 1
// - Pointer resets on reset/overflow, toggles each write
// - Out-of-sequence keys do not clear, pointer toggles
// - Clear register read returns pointer in bit0
// - Counter and pointer held after overflow briefly
// - Clear writes ignored about 15.25us after interrupt
// - Counter stops in stop mode
// - Counts in halt; interrupt wakes halt
`timescale 1ns/1ns
`default_nettype none
module free_running_watchdog (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic lsclk,
  input wire logic stop_mode,
  input wire logic halt_mode,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic watchdog_nmi_request,
  output logic watchdog_reset,
  output logic halt_release,
  output logic irq
);
  import wdt_pkg::*;

  wdt_tick_if tk ();
  logic [17:0] cnt_q;
  logic [17:0] ovf_limit;
  logic [1:0] overflow_period_q;
  logic clear_sequence_pointer_q;
  logic first_ovf_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_enable_q;
  logic lock_start_q;
  logic overflow;
  logic wr_clear;
  logic key_ok;
  logic key_armed_q;

  wdt_tick_gen u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .lsclk(lsclk),
    .stop_mode(stop_mode),
    .tk(tk)
  );

  // Overflow point from the selected period
  always_comb begin
    unique case (overflow_period_q)
      2'h0: ovf_limit = OVF_TICKS_125MS;
      2'h1: ovf_limit = OVF_TICKS_500MS;
      2'h2: ovf_limit = OVF_TICKS_2S;
      2'h3: ovf_limit = OVF_TICKS_8S;
    endcase
  end

  assign overflow = tk.tick && (cnt_q >= ovf_limit - 18'h00001);
  // Writes during lockout are dropped entirely, pointer too; lock_start_q
  // covers the cycle before the helper's lockout counter is loaded
  assign wr_clear = reg_wr && reg_addr == ADDR_CLEAR && !tk.locked && !lock_start_q;
  // Pointer alone would let any stray byte at pointer 0 arm a clear
  assign key_ok = wr_clear && clear_sequence_pointer_q && key_armed_q
                  && reg_wdata == KEY_SECOND;
  assign tk.lock_start = lock_start_q;

  // Counter: no software stop exists; only reset, the key sequence, an overflow or the lockout clears it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (key_ok || overflow) begin
      cnt_q <= '0;
    end else if (tk.locked || lock_start_q) begin
      cnt_q <= '0;
    end else if (tk.tick) begin
      cnt_q <= cnt_q + 18'h00001;
    end
  end

  // Pointer: a 5A at 1 toggles back to 0 without arming
  always_ff @(posedge clk_sys) begin
    if (rst || overflow) begin
      clear_sequence_pointer_q <= 1'b0;
    end else if (wr_clear) begin
      if (!clear_sequence_pointer_q && reg_wdata != KEY_FIRST) begin
        clear_sequence_pointer_q <= 1'b1;
      end else begin
        clear_sequence_pointer_q <= ~clear_sequence_pointer_q;
      end
    end
  end

  // Arming flag: a stray byte at pointer 0 still toggles, but must not arm
  always_ff @(posedge clk_sys) begin
    if (rst || overflow) begin
      key_armed_q <= 1'b0;
    end else if (wr_clear) begin
      key_armed_q <= !clear_sequence_pointer_q && reg_wdata == KEY_FIRST;
    end
  end

  // First overflow memory; overflow wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_ovf_q <= 1'b0;
    end else if (overflow) begin
      first_ovf_q <= 1'b1;
    end else if (key_ok) begin
      first_ovf_q <= 1'b0;
    end
  end

  // Event pulses and lockout start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_nmi_request <= 1'b0;
      watchdog_reset <= 1'b0;
      halt_release <= 1'b0;
      lock_start_q <= 1'b0;
    end else begin
      watchdog_nmi_request <= overflow && !first_ovf_q;
      watchdog_reset <= overflow && first_ovf_q;
      halt_release <= overflow && !first_ovf_q && halt_mode;
      lock_start_q <= overflow;
    end
  end

  // Period register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overflow_period_q <= PERIOD_RESET;
    end else if (reg_wr && reg_addr == ADDR_PERIOD) begin
      overflow_period_q <= reg_wdata[1:0];
    end
  end

  // Sticky status; a set beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status_q <= '0;
      irq_enable_q <= IRQ_ENABLE_RESET;
    end else begin
      if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) begin
        irq_enable_q <= reg_wdata[1:0];
      end
      irq_status_q <= (irq_status_q & ~((reg_wr && reg_addr == ADDR_IRQ_CLEAR) ?
                       reg_wdata[1:0] : 2'h0))
                      | {overflow && first_ovf_q, overflow && !first_ovf_q};
    end
  end

  // Level interrupt from enabled status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_CLEAR: reg_rdata <= {7'h00, clear_sequence_pointer_q};
        ADDR_PERIOD: reg_rdata <= {6'h00, overflow_period_q};
        ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status_q};
        ADDR_IRQ_ENABLE: reg_rdata <= {6'h00, irq_enable_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  sequence s_first_ovf;
    overflow && !first_ovf_q;
  endsequence
  property p_nmi_on_first;
    @(posedge clk_sys) disable iff (rst) s_first_ovf |=> watchdog_nmi_request && !watchdog_reset;
  endproperty
  a_nmi_on_first: assert property (p_nmi_on_first) else $error("no nmi on first overflow");
  property p_reset_on_second;
    @(posedge clk_sys) disable iff (rst) (overflow && first_ovf_q) |=> watchdog_reset;
  endproperty
  a_reset_on_second: assert property (p_reset_on_second) else $error("no reset");
  property p_ptr_toggle;
    @(posedge clk_sys) disable iff (rst) (wr_clear && !overflow)
      |=> clear_sequence_pointer_q != $past(clear_sequence_pointer_q);
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer not toggled");
  property p_ptr_zero_ovf;
    @(posedge clk_sys) disable iff (rst) overflow |=> !clear_sequence_pointer_q;
  endproperty
  a_ptr_zero_ovf: assert property (p_ptr_zero_ovf) else $error("pointer kept");
  property p_clear;
    @(posedge clk_sys) disable iff (rst) (key_ok && !overflow) |=> cnt_q == 18'h0 && !first_ovf_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_bad_key;
    @(posedge clk_sys) disable iff (rst) (wr_clear && reg_wdata == KEY_SECOND
      && !clear_sequence_pointer_q && !tk.tick) |=> cnt_q == $past(cnt_q);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key cleared");
  property p_rd_ptr;
    @(posedge clk_sys) disable iff (rst) (reg_rd && reg_addr == ADDR_CLEAR)
      |=> reg_rdata == {7'h00, $past(clear_sequence_pointer_q)};
  endproperty
  a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read wrong");
  property p_lockout;
    @(posedge clk_sys) disable iff (rst) overflow |=> ##1 tk.locked [*8];
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout too short");
  property p_stop;
    @(posedge clk_sys) disable iff (rst) stop_mode |=> !tk.tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick in stop");

  // Clear-sequence checks: key pair with a read-back between, as software does it
  sequence s_key_first;
    wr_clear && !clear_sequence_pointer_q && reg_wdata == KEY_FIRST;
  endsequence
  sequence s_key_second;
    wr_clear && clear_sequence_pointer_q && reg_wdata == KEY_SECOND;
  endsequence
  sequence s_stray_first;
    wr_clear && !clear_sequence_pointer_q && reg_wdata != KEY_FIRST;
  endsequence
  property p_key_pair;
    @(posedge clk_sys) disable iff (rst) s_key_first ##1 !wr_clear [*3] ##1 s_key_second
      |=> cnt_q == 18'h0;
  endproperty
  a_key_pair: assert property (p_key_pair) else $error("key pair did not clear");
  property p_unarmed;
    @(posedge clk_sys) disable iff (rst) s_stray_first ##1 !wr_clear [*3] ##1
      (wr_clear && clear_sequence_pointer_q && reg_wdata == KEY_SECOND && !tk.tick)
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed second key cleared");

  // Lockout checks
  property p_lock_hold;
    @(posedge clk_sys) disable iff (rst) tk.locked
      |-> cnt_q == 18'h0 && !clear_sequence_pointer_q;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("state moved in lockout");
  property p_lock_ignore;
    @(posedge clk_sys) disable iff (rst) (reg_wr && reg_addr == ADDR_CLEAR && tk.locked)
      |=> clear_sequence_pointer_q == $past(clear_sequence_pointer_q);
  endproperty
  a_lock_ignore: assert property (p_lock_ignore) else $error("write in lockout");
  property p_lock_after_nmi;
    @(posedge clk_sys) disable iff (rst) watchdog_nmi_request |=> tk.locked;
  endproperty
  a_lock_after_nmi: assert property (p_lock_after_nmi) else $error("no lockout");

  // Counting checks
  property p_count_up;
    @(posedge clk_sys) disable iff (rst)
      (tk.tick && !overflow && !key_ok && !tk.locked && !lock_start_q)
      |=> cnt_q == $past(cnt_q) + 18'h00001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not advance");
  property p_stop_hold;
    @(posedge clk_sys) disable iff (rst)
      stop_mode ##1 (stop_mode && !key_ok && !tk.locked && !lock_start_q)
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved in stop");
  property p_period_write;
    @(posedge clk_sys) disable iff (rst) (reg_wr && reg_addr == ADDR_PERIOD)
      |=> {6'h00, overflow_period_q} == ($past(reg_wdata) & 8'h03);
  endproperty
  a_period_write: assert property (p_period_write) else $error("period not taken");

  // Event output checks
  property p_halt_release;
    @(posedge clk_sys) disable iff (rst) (overflow && !first_ovf_q && halt_mode) |=> halt_release;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");
  property p_halt_only;
    @(posedge clk_sys) disable iff (rst) halt_release |-> watchdog_nmi_request;
  endproperty
  a_halt_only: assert property (p_halt_only) else $error("halt release without nmi");
  property p_reset_excl;
    @(posedge clk_sys) disable iff (rst) watchdog_reset |-> !watchdog_nmi_request;
  endproperty
  a_reset_excl: assert property (p_reset_excl) else $error("nmi and reset together");
  property p_reset_pulse;
    @(posedge clk_sys) disable iff (rst) watchdog_reset |=> !watchdog_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_status_sticky;
    @(posedge clk_sys) disable iff (rst)
      (irq_status_q[0] && !(reg_wr && reg_addr == ADDR_IRQ_CLEAR)) |=> irq_status_q[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");
endmodule : free_running_watchdog
`default_nettype wire

/* File: bench/wdt_far_side.sv */
// Far-side model: low-speed oscillator plus the chip's interrupt and reset logic.
// Assumes one clk_sys domain; the oscillator is scaled to one rising edge per 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module wdt_far_side (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic watchdog_nmi_request,
  input wire logic watchdog_reset,
  output logic lsclk,
  output var int nmi_count,
  output var int reset_count
);
  logic [1:0] div_q;

  // Oscillator restarts with reset; scaled so a short period fits the run
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign lsclk = div_q[1];

  // Tally of requests seen by the interrupt controller and reset logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nmi_count <= 0;
      reset_count <= 0;
    end else begin
      if (watchdog_nmi_request === 1'b1) nmi_count <= nmi_count + 1;
      if (watchdog_reset === 1'b1) reset_count <= reset_count + 1;
    end
  end
endmodule : wdt_far_side
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the watchdog: register tasks, event waits, verdict.
// Assumes the far-side model drives the low-speed clock and counts events.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import wdt_pkg::*;
  logic clk_sys, rst, stop_mode, halt_mode, reg_wr, reg_rd, lsclk;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic watchdog_nmi_request, watchdog_reset, halt_release, irq;
  int nmi_count, reset_count;
  int fail_count = 0;
  int checked = 0;

  // System clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  free_running_watchdog uut (.clk_sys(clk_sys), .rst(rst), .lsclk(lsclk),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .watchdog_nmi_request(watchdog_nmi_request), .watchdog_reset(watchdog_reset),
    .halt_release(halt_release), .irq(irq));

  wdt_far_side far (.clk_sys(clk_sys), .rst(rst), .watchdog_nmi_request(watchdog_nmi_request),
    .watchdog_reset(watchdog_reset), .lsclk(lsclk), .nmi_count(nmi_count),
    .reset_count(reset_count));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  // irq lags the register update by one cycle
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask : irq_chk

  // Event code: bit0 interrupt, bit1 reset, bit2 halt release
  task automatic wait_evt(input int limit, input logic [7:0] exp, input string what);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (!(watchdog_nmi_request === 1'b1 || watchdog_reset === 1'b1) && n < limit) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(what, exp, {5'h00, halt_release, watchdog_reset, watchdog_nmi_request});
  endtask : wait_evt

  // Key pair with read-back of the pointer after each write
  task automatic clear_counter();
    wr(ADDR_CLEAR, KEY_FIRST);
    rd(ADDR_CLEAR, 8'h01, "pointer after first key");
    wr(ADDR_CLEAR, KEY_SECOND);
    rd(ADDR_CLEAR, 8'h00, "pointer after second key");
  endtask : clear_counter

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Cuts a hang short; tests need about 70000 cycles
  initial begin
    repeat (95000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    stop_mode = 1'b0;
    halt_mode = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_PERIOD, {6'h00, PERIOD_RESET}, "period reset");
    rd(ADDR_CLEAR, 8'h00, "pointer reset");
    rd(16'hF0F0, 8'h00, "unmapped read");
    wr(ADDR_PERIOD, 8'h03);
    rd(ADDR_PERIOD, 8'h03, "period longest");
    wr(ADDR_PERIOD, 8'hFD);
    rd(ADDR_PERIOD, 8'h01, "period field only");
    wr(ADDR_PERIOD, 8'h00);
    rd(ADDR_PERIOD, 8'h00, "period shortest");
    wr(ADDR_CLEAR, 8'h33);
    rd(ADDR_CLEAR, 8'h01, "pointer any value");
    wr(ADDR_CLEAR, KEY_FIRST);
    rd(ADDR_CLEAR, 8'h00, "first key at pointer one");
    wr(ADDR_CLEAR, KEY_SECOND);
    rd(ADDR_CLEAR, 8'h01, "second key unarmed");
    wr(ADDR_CLEAR, KEY_SECOND);
    rd(ADDR_CLEAR, 8'h00, "second key after stray byte");
    clear_counter();
    stop_mode <= 1'b1;
    wait_evt(20000, 8'h00, "no overflow while stopped");
    stop_mode <= 1'b0;
    halt_mode <= 1'b1;
    wait_evt(17000, 8'h05, "first overflow in halt");
    wr(ADDR_CLEAR, KEY_FIRST);
    rd(ADDR_CLEAR, 8'h00, "write during lockout");
    halt_mode <= 1'b0;
    rd(ADDR_IRQ_STATUS, 8'h01, "status after interrupt");
    wr(ADDR_IRQ_STATUS, 8'hFF);
    rd(ADDR_IRQ_STATUS, 8'h01, "status not writable");
    irq_chk(1'b1);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    irq_chk(1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h03);
    irq_chk(1'b1);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    irq_chk(1'b0);
    repeat (LOCKOUT_CYCLES) @(posedge clk_sys);
    clear_counter();
    wait_evt(17000, 8'h01, "overflow after clear");
    wait_evt(17000, 8'h02, "second overflow");
    rd(ADDR_IRQ_STATUS, 8'h03, "status after reset event");
    chk("nmi count", 8'h02, nmi_count[7:0]);
    chk("reset count", 8'h01, reset_count[7:0]);
    summarize();
  end
endmodule : tb
`default_nettype wire
